//--- hw/daq_regs_pkg.sv
// Shared constants and types of the acquisition register bank
package daq_regs_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_MHZ = 40;
  localparam int unsigned DAC_UPDATE_NS = 50;
  localparam int unsigned DAC_UPDATE_RAW = (DAC_UPDATE_NS * CLK_MHZ) / 1000;
  localparam int unsigned DAC_UPDATE_INT = (DAC_UPDATE_RAW < 1) ? 1 : DAC_UPDATE_RAW;
  localparam logic [1:0] DAC_UPDATE_CYC = 2'(DAC_UPDATE_INT);
  ////////////////////////////////////////////////////////////////////////////
  // Register indexes, byte address is four times the index
  localparam logic [5:0] IDX_REQ_CLEAR = 6'h00;
  localparam logic [5:0] IDX_DAC_LOW = 6'h06;
  localparam logic [5:0] IDX_QUEUE_STATUS = 6'h06;
  localparam logic [5:0] IDX_DAC_HIGH = 6'h07;
  localparam logic [5:0] IDX_ANALOG_STATE = 6'h07;
  localparam logic [5:0] IDX_PORT_A = 6'h08;
  localparam logic [5:0] IDX_PORT_B = 6'h09;
  localparam logic [5:0] IDX_DIO_DA_CTRL = 6'h0B;
  localparam logic [5:0] IDX_QUEUE_CTRL = 6'h0C;
  localparam logic [5:0] IDX_SYNC_UPDATE = 6'h0F;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h10;
  localparam logic [5:0] IDX_IRQ_ENABLE = 6'h11;
  localparam logic [5:0] IDX_IRQ_CLEAR = 6'h12;
  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int HB_CHAN_MSB = 7;
  localparam int HB_CHAN_LSB = 6;
  localparam int HB_DATA_MSB = 3;
  localparam int QS_OVERRUN = 3;
  localparam int QS_FULL = 2;
  localparam int QS_HALF = 1;
  localparam int QS_EMPTY = 0;
  localparam int REQ_MSB = 6;
  localparam int REQ_LSB = 4;
  localparam int CTRL_SIM = 5;
  localparam int CTRL_DIR_A = 4;
  localparam int CTRL_DIR_B = 1;
  localparam int QCTRL_ENHANCED = 0;
  localparam int QCTRL_RESET = 1;
  localparam int IRQ_DAC_DONE = 0;
  localparam int IRQ_OVERRUN = 1;
  localparam int IRQ_REQUEST = 2;
  ////////////////////////////////////////////////////////////////////////////
  // Queue geometry and reset values
  localparam logic [11:0] QUEUE_DEPTH = 12'h800;
  localparam logic [11:0] QUEUE_HALF = 12'h400;
  localparam logic [7:0] PORT_RESET = 8'h00;
  localparam logic [7:0] DAC_LOW_RESET = 8'h00;
  localparam logic [3:0] DAC_HIGH_RESET = 4'h0;
  localparam logic [2:0] IRQ_EN_RESET = 3'h0;
  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {BUS_IDLE = 2'b01, BUS_ACK = 2'b10} bus_state_t;
  typedef enum logic [1:0] {UPD_IDLE = 2'b01, UPD_LOAD = 2'b10} upd_state_t;
  typedef struct packed {
    logic load;
    logic [1:0] channel;
    logic [11:0] value;
  } dac_out_t;
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe_n;
  } dio_port_t;
endpackage

//--- hw/sticky_flag.sv
// Sticky flag group, a set in the same cycle as a clear wins
`timescale 1ns/1ps
`default_nettype none
module sticky_flag #(
  parameter int W = 3
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Events and clears
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  output var logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] flags;
  } flag_state_t;
  flag_state_t st_r, st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.flags = (st_r.flags & ~clr) | set;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign q = st_r.flags;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  chk_set_beats_clear: assert property ((set & clr) != '0 |=> (q & $past(set & clr)) != '0)
    else $error("flag lost when set met clear");
endmodule
`default_nettype wire

//--- hw/dac_update_pulser.sv
// Converter update strobe, holds the new code and load for the update time
`timescale 1ns/1ps
`default_nettype none
module dac_update_pulser (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Update request
  input wire logic start,
  input wire logic [1:0] channel,
  input wire logic [11:0] value,
  // Converter side
  output var daq_regs_pkg::dac_out_t dac_out,
  output var logic done
);
  typedef struct packed {
    daq_regs_pkg::upd_state_t mode;
    logic [1:0] cnt;
    daq_regs_pkg::dac_out_t out;
    logic done;
  } upd_t;
  upd_t st_r, st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    if (start)
    begin
      st_nxt.mode = daq_regs_pkg::UPD_LOAD;
      st_nxt.out.load = 1'b1;
      st_nxt.out.channel = channel;
      st_nxt.out.value = value;
      st_nxt.cnt = daq_regs_pkg::DAC_UPDATE_CYC - 2'h1;
    end
    else
    begin
      unique case (st_r.mode)
        daq_regs_pkg::UPD_IDLE:
          st_nxt.out.load = 1'b0;
        daq_regs_pkg::UPD_LOAD:
          if (st_r.cnt == 2'h0)
          begin
            st_nxt.mode = daq_regs_pkg::UPD_IDLE;
            st_nxt.out.load = 1'b0;
            st_nxt.done = 1'b1;
          end
          else
            st_nxt.cnt = st_r.cnt - 2'h1;
        default:
          st_nxt.mode = daq_regs_pkg::UPD_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      st_r <= '{mode: daq_regs_pkg::UPD_IDLE, cnt: 2'h0, out: '0, done: 1'b0};
    else
      st_r <= st_nxt;
  end

  assign dac_out = st_r.out;
  assign done = st_r.done;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  chk_update_time: assert property ($rose(dac_out.load) |-> dac_out.load[*2] ##1 (!dac_out.load || $past(start)))
    else $error("converter load not held for the update time");
endmodule
`default_nettype wire

//--- hw/daq_dac_fifo_dio_regs.sv
// Acquisition register bank: converter load, queue status, requests, digital ports
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module daq_dac_fifo_dio_regs (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output var logic [31:0] avs_readdata,
  output var logic avs_waitrequest,
  // Acquisition side
  input wire logic adc_push,
  input wire logic queue_pop,
  input wire logic [3:0] next_sample_channel,
  input wire logic timer_event,
  input wire logic dio_event,
  input wire logic adc_event,
  // Converter
  output var daq_regs_pkg::dac_out_t dac_out,
  // Digital ports
  input wire logic [7:0] port_a_in,
  input wire logic [7:0] port_b_in,
  output var daq_regs_pkg::dio_port_t port_a,
  output var daq_regs_pkg::dio_port_t port_b,
  // Interrupt
  output var logic irq
);
  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    daq_regs_pkg::bus_state_t bus;
    logic [31:0] rdata;
    logic [7:0] dac_value_low;
    logic [3:0] dac_value_high;
    logic [1:0] output_channel_select;
    logic simultaneous_update_mode;
    logic dir_a;
    logic dir_b;
    logic enhanced_queue_mode;
    logic [7:0] port_a_out;
    logic [7:0] port_b_out;
    logic [11:0] queue_sample_count;
    logic queue_overrun_flag;
    logic [2:0] irq_en;
  } regs_t;

  localparam regs_t REGS_RESET = '{
    bus: daq_regs_pkg::BUS_IDLE,
    rdata: 32'h0000_0000,
    dac_value_low: daq_regs_pkg::DAC_LOW_RESET,
    dac_value_high: daq_regs_pkg::DAC_HIGH_RESET,
    output_channel_select: 2'h0,
    simultaneous_update_mode: 1'b0,
    dir_a: 1'b1,
    dir_b: 1'b1,
    enhanced_queue_mode: 1'b0,
    port_a_out: daq_regs_pkg::PORT_RESET,
    port_b_out: daq_regs_pkg::PORT_RESET,
    queue_sample_count: 12'h000,
    queue_overrun_flag: 1'b0,
    irq_en: daq_regs_pkg::IRQ_EN_RESET
  };

  regs_t st_r, st_nxt;

  logic [5:0] idx;
  logic acc;
  logic wr_acc;
  logic rd_acc;
  logic wr_high;
  logic upd_start;
  logic [11:0] upd_value;
  logic [1:0] upd_channel;
  logic upd_done;
  logic queue_full_flag;
  logic queue_half_flag;
  logic queue_empty_flag;
  logic queue_reset;
  logic push_ok;
  logic pop_ok;
  logic overrun_event;
  logic [2:0] req_set;
  logic [2:0] req_clr;
  logic [2:0] req_pending;
  logic [2:0] irq_set;
  logic [2:0] irq_clr;
  logic [2:0] irq_status;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode, one wait cycle then accept
  assign idx = avs_address[7:2];
  assign acc = (st_r.bus == daq_regs_pkg::BUS_ACK);
  assign wr_acc = acc && avs_write && avs_byteenable[0];
  assign rd_acc = acc && avs_read;
  assign avs_waitrequest = !acc;
  assign avs_readdata = st_r.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Converter update
  // unused high-byte bits dropped
  assign wr_high = wr_acc && (idx == daq_regs_pkg::IDX_DAC_HIGH);
  assign upd_value = wr_high
    ? {avs_writedata[daq_regs_pkg::HB_DATA_MSB:0], st_r.dac_value_low}
    : {st_r.dac_value_high, st_r.dac_value_low};
  assign upd_channel = wr_high
    ? avs_writedata[daq_regs_pkg::HB_CHAN_MSB:daq_regs_pkg::HB_CHAN_LSB]
    : st_r.output_channel_select;
  assign upd_start = (wr_high && !st_r.simultaneous_update_mode)
    || (rd_acc && (idx == daq_regs_pkg::IDX_SYNC_UPDATE) && st_r.simultaneous_update_mode);

  dac_update_pulser u_pulser (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .start(upd_start),
    .channel(upd_channel),
    .value(upd_value),
    .dac_out(dac_out),
    .done(upd_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Queue occupancy
  // full flag
  assign queue_full_flag = (st_r.queue_sample_count == daq_regs_pkg::QUEUE_DEPTH);
  assign queue_half_flag = (st_r.queue_sample_count >= daq_regs_pkg::QUEUE_HALF);
  assign queue_empty_flag = (st_r.queue_sample_count == 12'h000);
  assign queue_reset = wr_acc && (idx == daq_regs_pkg::IDX_QUEUE_CTRL)
    && avs_writedata[daq_regs_pkg::QCTRL_RESET];
  // refuse samples when full or overrun
  assign push_ok = adc_push && !queue_full_flag && !st_r.queue_overrun_flag;
  assign pop_ok = queue_pop && !queue_empty_flag;
  assign overrun_event = adc_push && queue_full_flag && !st_r.queue_overrun_flag;

  ////////////////////////////////////////////////////////////////////////////
  // Pending requests and interrupt status
  assign req_set = {timer_event, dio_event, adc_event};
  assign req_clr = (wr_acc && (idx == daq_regs_pkg::IDX_REQ_CLEAR))
    ? avs_writedata[daq_regs_pkg::REQ_MSB:daq_regs_pkg::REQ_LSB] : 3'h0;

  sticky_flag #(.W(3)) u_pending (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .set(req_set),
    .clr(req_clr),
    .q(req_pending)
  );

  always_comb
  begin
    irq_set = 3'h0;
    irq_set[daq_regs_pkg::IRQ_DAC_DONE] = upd_done;
    irq_set[daq_regs_pkg::IRQ_OVERRUN] = overrun_event;
    irq_set[daq_regs_pkg::IRQ_REQUEST] = |req_set;
  end
  assign irq_clr = (wr_acc && (idx == daq_regs_pkg::IDX_IRQ_CLEAR)) ? avs_writedata[2:0] : 3'h0;

  sticky_flag #(.W(3)) u_irq_status (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .set(irq_set),
    .clr(irq_clr),
    .q(irq_status)
  );

  assign irq = |(irq_status & st_r.irq_en);

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    logic [7:0] rb;
    rb = 8'h00;
    st_nxt = st_r;
    unique case (st_r.bus)
      daq_regs_pkg::BUS_IDLE:
        if (avs_read || avs_write)
          st_nxt.bus = daq_regs_pkg::BUS_ACK;
      daq_regs_pkg::BUS_ACK:
        st_nxt.bus = daq_regs_pkg::BUS_IDLE;
      default:
        st_nxt.bus = daq_regs_pkg::BUS_IDLE;
    endcase
    // Read word captured before the accept edge, no side effect here
    case (idx)
      daq_regs_pkg::IDX_QUEUE_STATUS:
        if (st_r.enhanced_queue_mode)
          rb = {st_r.queue_sample_count[11:8], st_r.queue_overrun_flag,
                queue_full_flag, queue_half_flag, queue_empty_flag};
        else
          rb = st_r.queue_sample_count[7:0];
      daq_regs_pkg::IDX_ANALOG_STATE:
        rb = {1'b0, req_pending, next_sample_channel};
      daq_regs_pkg::IDX_PORT_A:
        rb = st_r.dir_a ? port_a_in : st_r.port_a_out;
      daq_regs_pkg::IDX_PORT_B:
        rb = st_r.dir_b ? port_b_in : st_r.port_b_out;
      daq_regs_pkg::IDX_DIO_DA_CTRL:
      begin
        rb[daq_regs_pkg::CTRL_SIM] = st_r.simultaneous_update_mode;
        rb[daq_regs_pkg::CTRL_DIR_A] = st_r.dir_a;
        rb[daq_regs_pkg::CTRL_DIR_B] = st_r.dir_b;
      end
      daq_regs_pkg::IDX_QUEUE_CTRL:
        rb[daq_regs_pkg::QCTRL_ENHANCED] = st_r.enhanced_queue_mode;
      daq_regs_pkg::IDX_IRQ_STATUS:
        rb = {5'h00, irq_status};
      daq_regs_pkg::IDX_IRQ_ENABLE:
        rb = {5'h00, st_r.irq_en};
      default:
        rb = 8'h00;
    endcase
    if ((st_r.bus == daq_regs_pkg::BUS_IDLE) && avs_read)
      st_nxt.rdata = {24'h00_0000, rb};
    // Register writes at the accept edge
    if (wr_acc)
    begin
      case (idx)
        daq_regs_pkg::IDX_DAC_LOW:
          st_nxt.dac_value_low = avs_writedata[7:0];
        daq_regs_pkg::IDX_DAC_HIGH:
        begin
          st_nxt.dac_value_high = avs_writedata[daq_regs_pkg::HB_DATA_MSB:0];
          st_nxt.output_channel_select =
            avs_writedata[daq_regs_pkg::HB_CHAN_MSB:daq_regs_pkg::HB_CHAN_LSB];
        end
        daq_regs_pkg::IDX_PORT_A:
          st_nxt.port_a_out = avs_writedata[7:0];
        daq_regs_pkg::IDX_PORT_B:
          st_nxt.port_b_out = avs_writedata[7:0];
        daq_regs_pkg::IDX_DIO_DA_CTRL:
        begin
          st_nxt.simultaneous_update_mode = avs_writedata[daq_regs_pkg::CTRL_SIM];
          st_nxt.dir_a = avs_writedata[daq_regs_pkg::CTRL_DIR_A];
          st_nxt.dir_b = avs_writedata[daq_regs_pkg::CTRL_DIR_B];
        end
        daq_regs_pkg::IDX_QUEUE_CTRL:
          st_nxt.enhanced_queue_mode = avs_writedata[daq_regs_pkg::QCTRL_ENHANCED];
        daq_regs_pkg::IDX_IRQ_ENABLE:
          st_nxt.irq_en = avs_writedata[2:0];
        default:
          st_nxt.irq_en = st_r.irq_en;
      endcase
    end
    // sticky overrun, cleared only by queue reset
    if (queue_reset)
    begin
      st_nxt.queue_sample_count = 12'h000;
      st_nxt.queue_overrun_flag = 1'b0;
    end
    else
    begin
      st_nxt.queue_sample_count = st_r.queue_sample_count
        + {11'h000, push_ok} - {11'h000, pop_ok};
      st_nxt.queue_overrun_flag = st_r.queue_overrun_flag || (adc_push && queue_full_flag);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      st_r <= REGS_RESET;
    else
      st_r <= st_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port pins, enable low while driving
  assign port_a.out = st_r.port_a_out;
  assign port_a.oe_n = {8{st_r.dir_a}};
  assign port_b.out = st_r.port_b_out;
  assign port_b.oe_n = {8{st_r.dir_b}};

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence s_high_write;
    wr_high && !st_r.simultaneous_update_mode;
  endsequence
  sequence s_sync_read;
    rd_acc && (idx == daq_regs_pkg::IDX_SYNC_UPDATE) && st_r.simultaneous_update_mode;
  endsequence
  sequence s_status_read(logic [5:0] i);
    (st_r.bus == daq_regs_pkg::BUS_IDLE) && avs_read && (idx == i);
  endsequence

  chk_direct_update: assert property (s_high_write |=> dac_out.load)
    else $error("high write did not start the update");
  chk_code_form: assert property (s_high_write |=> dac_out.value
      == {$past(avs_writedata[3:0]), $past(st_r.dac_value_low)})
    else $error("converter code mis-assembled");
  chk_channel_pick: assert property (s_high_write |=> dac_out.channel == $past(avs_writedata[7:6]))
    else $error("wrong output channel");
  chk_sync_load_only: assert property (wr_high && st_r.simultaneous_update_mode
      && !dac_out.load |=> !dac_out.load)
    else $error("update without sync read");
  chk_sync_update: assert property (s_sync_read |=> dac_out.load)
    else $error("sync read did not update");
  chk_basic_depth: assert property (s_status_read(daq_regs_pkg::IDX_QUEUE_STATUS)
      ##0 !st_r.enhanced_queue_mode
      |=> avs_readdata[7:0] == $past(st_r.queue_sample_count[7:0]))
    else $error("basic depth read wrong");
  chk_enh_flags: assert property (s_status_read(daq_regs_pkg::IDX_QUEUE_STATUS)
      ##0 st_r.enhanced_queue_mode |=> avs_readdata[3:0] == {$past(st_r.queue_overrun_flag),
      $past(queue_full_flag), $past(queue_half_flag), $past(queue_empty_flag)})
    else $error("enhanced status read wrong");
  chk_overrun_blocks: assert property (st_r.queue_overrun_flag && !queue_reset && !queue_pop
      |=> st_r.queue_overrun_flag && st_r.queue_sample_count == $past(st_r.queue_sample_count))
    else $error("sample accepted after overrun");
  chk_full_reached: assert property (st_r.queue_sample_count == 12'h7FF && push_ok && !queue_pop
      && !queue_reset |=> queue_full_flag)
    else $error("full flag missing");
  chk_half_reached: assert property (st_r.queue_sample_count == 12'h3FF && push_ok && !queue_pop
      && !queue_reset |=> queue_half_flag
      ##1 (queue_half_flag || $past(queue_pop) || $past(queue_reset)))
    else $error("half flag missing");
  chk_empty_reached: assert property (st_r.queue_sample_count == 12'h001 && queue_pop && !adc_push
      && !queue_reset |=> queue_empty_flag)
    else $error("empty flag missing");
  chk_timer_pending: assert property (timer_event ##2 s_status_read(daq_regs_pkg::IDX_ANALOG_STATE)
      |=> avs_readdata[6])
    else $error("timer request not reported");
  chk_next_channel: assert property (s_status_read(daq_regs_pkg::IDX_ANALOG_STATE)
      |=> avs_readdata[3:0] == $past(next_sample_channel))
    else $error("next channel not reported");
  chk_port_a_write: assert property (wr_acc && idx == daq_regs_pkg::IDX_PORT_A
      |=> port_a.out == $past(avs_writedata[7:0]))
    else $error("port A write lost");
  chk_port_b_dir: assert property (wr_acc && idx == daq_regs_pkg::IDX_DIO_DA_CTRL
      |=> port_b.oe_n == {8{$past(avs_writedata[1])}})
    else $error("port B direction wrong");
  chk_read_keeps: assert property (rd_acc && idx == daq_regs_pkg::IDX_ANALOG_STATE
      |=> (req_pending & $past(req_pending)) == $past(req_pending))
    else $error("status read cleared a request");
endmodule
`default_nettype wire

//--- test/acq_side_model.sv
// Acquisition side and pin model facing the register bank
`timescale 1ns/1ps
`default_nettype none
module acq_side_model (
  // Clock
  input wire logic ref_clk,
  // Pins
  input wire daq_regs_pkg::dio_port_t port_a,
  input wire daq_regs_pkg::dio_port_t port_b,
  input wire logic [7:0] ext_a,
  output var logic [7:0] pins_a,
  output var logic [7:0] pins_b,
  // Queue traffic
  output var logic adc_push,
  output var logic queue_pop
);
  initial adc_push = 1'b0;
  initial queue_pop = 1'b0;
  ////////////////////////////////////////////////////////////
  // Undriven lines show an outside pattern
  assign pins_a = (port_a.oe_n & ext_a) | (~port_a.oe_n & port_a.out);
  assign pins_b = (port_b.oe_n & ~ext_a) | (~port_b.oe_n & port_b.out);
  ////////////////////////////////////////////////////////////
  // One sample per cycle
  task automatic push(input int k);
    repeat (k)
    begin
      @(posedge ref_clk);
      adc_push <= 1'b1;
    end
    @(posedge ref_clk);
    adc_push <= 1'b0;
  endtask
  task automatic pop;
    @(posedge ref_clk);
    queue_pop <= 1'b1;
    @(posedge ref_clk);
    queue_pop <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- test/testbench.sv
// Self-checking bench for the acquisition register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic adc_push;
  logic queue_pop;
  logic [3:0] chan = 4'hA;
  logic [2:0] ev = 3'h0;
  logic [7:0] pins_a;
  logic [7:0] pins_b;
  logic [7:0] ext_a = 8'h3C;
  logic [7:0] rd;
  logic irq;
  daq_regs_pkg::dac_out_t dac_out;
  daq_regs_pkg::dio_port_t port_a;
  daq_regs_pkg::dio_port_t port_b;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  int w;
  always #12.5 ref_clk = ~ref_clk;
  daq_dac_fifo_dio_regs i_dut (.ref_clk, .rstn, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .adc_push,
    .queue_pop, .next_sample_channel(chan), .timer_event(ev[2]), .dio_event(ev[1]),
    .adc_event(ev[0]), .dac_out, .port_a_in(pins_a), .port_b_in(pins_b), .port_a,
    .port_b, .irq);
  acq_side_model i_acq (.ref_clk, .port_a, .port_b, .ext_a, .pins_a, .pins_b,
    .adc_push, .queue_pop);
  ////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One bus access, held until waitrequest is seen low
  task automatic acc(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
    @(posedge ref_clk);
    avs_address <= {idx, 2'b00};
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= {24'h0, wd};
    do
    begin
      @(negedge ref_clk);
    end
    while (avs_waitrequest !== 1'b0);
    @(posedge ref_clk);
    rd = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic watch(output int k);
    k = 0;
    @(negedge ref_clk);
    while (dac_out.load !== 1'b1 && k < 6)
    begin
      @(negedge ref_clk);
      k++;
    end
  endtask
  task automatic dac_chk(input logic [13:0] exp);
    int k;
    watch(k);
    chk({2'b00, dac_out.channel, dac_out.value}, {2'b00, exp});
    k = 0;
    while (dac_out.load === 1'b1 && k < 9)
    begin
      @(negedge ref_clk);
      k++;
    end
    chk(16'(k), 16'd2);
  endtask
  ////////////////////////////////////////////////////////////
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 12000)
    begin
      err_total = err_total + 1;
      final_report();
    end
  end
  initial
  begin
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    acc(0, 6'h06, 8'h00);
    chk(rd, 8'h00);
    acc(0, 6'h07, 8'h00);
    chk(rd, 8'h0A);
    acc(0, 6'h08, 8'h00);
    chk(rd, 8'h3C);
    acc(0, 6'h09, 8'h00);
    chk(rd, 8'hC3);
    acc(0, 6'h20, 8'h00);
    chk(rd, 8'h00);
    $display("reset test finished");
    acc(1, 6'h11, 8'h01);
    for (int c = 0; c < 4; c++)
    begin
      acc(1, 6'h06, 8'(8'h5A + c));
      acc(1, 6'h07, {2'(c), 6'h39});
      dac_chk({2'(c), 4'h9, 8'(8'h5A + c)});
    end
    repeat (2) @(negedge ref_clk);
    chk(irq, 1'b1);
    acc(1, 6'h11, 8'h00);
    @(negedge ref_clk);
    chk(irq, 1'b0);
    acc(1, 6'h11, 8'h01);
    @(negedge ref_clk);
    chk(irq, 1'b1);
    acc(1, 6'h12, 8'h01);
    @(negedge ref_clk);
    chk(irq, 1'b0);
    $display("converter test finished");
    acc(1, 6'h0B, 8'h32);
    acc(1, 6'h06, 8'hC4);
    acc(1, 6'h07, 8'h47);
    watch(w);
    chk(16'(w), 16'd6);
    acc(0, 6'h0F, 8'h00);
    dac_chk({2'd1, 12'h7C4});
    $display("simultaneous test finished");
    for (int k = 0; k < 3; k++)
    begin
      @(posedge ref_clk);
      ev <= 3'(1 << k);
      @(posedge ref_clk);
      ev <= 3'h0;
      acc(0, 6'h07, 8'h00);
      chk(rd, 8'h0A | 8'(8'h10 << k));
      acc(0, 6'h07, 8'h00);
      chk(rd, 8'h0A | 8'(8'h10 << k));
      acc(1, 6'h00, 8'(8'h10 << k));
      acc(0, 6'h07, 8'h00);
      chk(rd, 8'h0A);
    end
    ev <= 3'h4;
    acc(1, 6'h00, 8'h40);
    ev <= 3'h0;
    acc(0, 6'h07, 8'h00);
    chk(rd, 8'h4A);
    acc(1, 6'h00, 8'h40);
    acc(0, 6'h07, 8'h00);
    chk(rd, 8'h0A);
    $display("request test finished");
    acc(1, 6'h0B, 8'h00);
    acc(1, 6'h08, 8'hA5);
    acc(1, 6'h09, 8'h5B);
    acc(0, 6'h08, 8'h00);
    chk(rd, 8'hA5);
    chk(port_a.out, 8'hA5);
    chk(port_a.oe_n, 8'h00);
    acc(0, 6'h09, 8'h00);
    chk(rd, 8'h5B);
    chk(port_b.oe_n, 8'h00);
    chk(port_b.out, 8'h5B);
    acc(1, 6'h0B, 8'h12);
    $display("port test finished");
    i_acq.push(3);
    i_acq.pop();
    acc(0, 6'h06, 8'h00);
    chk(rd, 8'h02);
    acc(1, 6'h0C, 8'h01);
    i_acq.push(1022);
    acc(0, 6'h06, 8'h00);
    chk(rd, 8'h42);
    i_acq.push(1024);
    acc(0, 6'h06, 8'h00);
    chk(rd, 8'h86);
    i_acq.push(2);
    acc(0, 6'h06, 8'h00);
    chk(rd, 8'h8E);
    acc(1, 6'h0C, 8'h03);
    acc(0, 6'h06, 8'h00);
    chk(rd, 8'h01);
    i_acq.push(1);
    i_acq.pop();
    acc(0, 6'h06, 8'h00);
    chk(rd, 8'h01);
    $display("queue test finished");
    final_report();
  end
endmodule
`default_nettype wire
